// ==== design/lbbpc_top.sv ====
// Purpose: brightness mapping for banks A to H, sink routing and charge pump gain control
// Assumes: all config ports come from logic on clk_sys_in; headroom and capacitor
//          detect come from analog comparators and are synchronised here
// Notes:   levels are 16-bit fractions of full scale; the analog side scales them
`timescale 1ns/1ps
module lbbpc_top
(
  input  wire logic              clk_sys_in,
  input  wire logic              resetn_in,
  input  wire logic              hv_linear_in,
  input  wire logic [1:0]        hv_wide_in,
  input  wire logic [1:0]        hv_lsb_wr_in,
  input  wire logic [1:0]        hv_msb_wr_in,
  input  wire logic [1:0][2:0]   hv_lsb_in,
  input  wire logic [1:0][7:0]   hv_msb_in,
  input  wire logic [1:0]        hv_pwm_en_in,
  input  wire logic [7:0]        pwm_duty_in,
  input  wire logic [1:0]        hv_ramp_sel_in,
  input  wire logic [3:0]        hv_start_time_in,
  input  wire logic [3:0]        hv_stop_time_in,
  input  wire logic [3:0]        hv_rt_up_in,
  input  wire logic [3:0]        hv_rt_down_in,
  input  wire logic              lv_linear_in,
  input  wire logic [5:0]        lv_bank_en_in,
  input  wire logic [5:0][7:0]   lv_bright_in,
  input  wire logic [5:0][4:0]   lv_fullscale_in,
  input  wire logic [5:0]        lv_pattern_en_in,
  input  wire logic [5:0][7:0]   lv_pattern_code_in,
  input  wire logic [5:0][1:0]   lv_sink_sel_in,
  input  wire logic              fb_en_wr_in,
  input  wire logic [5:0]        fb_en_data_in,
  input  wire logic [1:0]        pump_mode_in,
  input  wire logic [5:0]        headroom_low_in,
  input  wire logic              flying_capacitor_found_in,
  output logic      [1:0][15:0]  hv_level_out,
  output logic      [3:0]        hv_rt_up_eff_out,
  output logic      [3:0]        hv_rt_down_eff_out,
  output logic                   hv_rt_instant_out,
  output logic      [5:0][15:0]  lv_sink_level_out,
  output logic      [5:0][4:0]   lv_sink_fullscale_out,
  output logic      [5:0]        lv_sink_on_out,
  output logic      [5:0]        fb_en_out,
  output logic                   pump_pass_en_out,
  output logic                   pump_switch_en_out,
  output logic                   pump_gain2x_out,
  output logic      [2:0]        pump_state_out
);
  localparam int NB = lbbpc_pkg::NUM_HV + lbbpc_pkg::NUM_LV;

  // bank in group chosen by a sink; code 3 falls back to the sink's own bank
  function automatic logic [2:0] sink_bank(input logic [2:0] sink, input logic [1:0] sel);
    logic [2:0] base;
    base = (sink >= 3'(lbbpc_pkg::GROUP_SIZE)) ? 3'(lbbpc_pkg::GROUP_SIZE) : 3'h0;
    if (sel == 2'h3)
      return sink;
    return base + 3'(sel);
  endfunction : sink_bank

  logic [1:0][2:0]            lsb_hold_reg;
  logic [1:0][10:0]           hv_code_reg;
  logic [1:0]                 hv_wide_reg;
  logic [1:0][15:0]           hv_map_level;
  logic [5:0][15:0]           lv_bank_level_reg;
  logic [5:0][15:0]           lv_map_level;
  logic [5:0]                 lv_bank_on;
  logic [5:0]                 fb_en_reg;
  logic [5:0]                 head_meta_reg;
  logic [5:0]                 head_sync_reg;
  logic                       cap_meta_reg;
  logic                       cap_sync_reg;
  logic [7:0]                 det_cnt_reg;
  logic [7:0]                 det_cnt_next;
  logic [5:0]                 sink_on_next;
  logic                       boost_req;
  logic                       any_active;
  lbbpc_pkg::lbbpc_pump_t     pump_reg;
  lbbpc_pkg::lbbpc_pump_t     pump_next;

  lbbpc_map_if map_bus [NB] ();

  // one mapper per bank; A and B share one mode, C to H share another
  for (genvar b = 0; b < NB; b++)
  begin : g_map
    lbbpc_mapper u_map
    (
      .m (map_bus[b])
    );
    if (b < lbbpc_pkg::NUM_HV)
    begin : g_hv
      assign map_bus[b].code    = hv_code_reg[b];
      assign map_bus[b].wide    = hv_wide_reg[b];
      assign map_bus[b].linear  = hv_linear_in;
      assign hv_map_level[b]    = map_bus[b].level;
    end
    else
    begin : g_lv
      localparam int L = b - lbbpc_pkg::NUM_HV;
      // pattern generator code replaces the register code when enabled
      assign map_bus[b].code    = {3'h0, lv_pattern_en_in[L] ? lv_pattern_code_in[L]
                                                            : lv_bright_in[L]};
      assign map_bus[b].wide    = 1'b0;
      assign map_bus[b].linear  = lv_linear_in;
      assign lv_map_level[L]    = map_bus[b].level;
      assign lv_bank_on[L]      = lv_bank_en_in[L] && (map_bus[b].code != 11'h000);
    end
  end

  // LSB writes only park the low bits
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
      lsb_hold_reg <= '0;
    else
      for (int i = 0; i < lbbpc_pkg::NUM_HV; i++)
        if (hv_lsb_wr_in[i])
          lsb_hold_reg[i] <= hv_lsb_in[i];
  end

  // the code takes effect only on an MSB write
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      hv_code_reg <= '0;
      hv_wide_reg <= '0;
    end
    else
      for (int i = 0; i < lbbpc_pkg::NUM_HV; i++)
        if (hv_msb_wr_in[i])
        begin
          hv_wide_reg[i] <= hv_wide_in[i];
          if (hv_wide_in[i])
            hv_code_reg[i] <= {hv_msb_in[i], hv_lsb_wr_in[i] ? hv_lsb_in[i]
                                                            : lsb_hold_reg[i]};
          else
            hv_code_reg[i] <= {3'h0, hv_msb_in[i]};
        end
  end

  // high-voltage level, scaled by duty when PWM is enabled; 255 gives the level itself
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
      hv_level_out <= '0;
    else
      for (int i = 0; i < lbbpc_pkg::NUM_HV; i++)
      begin
        if (hv_pwm_en_in[i])
          hv_level_out[i] <= 16'((25'(hv_map_level[i]) * (25'(pwm_duty_in) + 25'h1)) >> 8);
        else
          hv_level_out[i] <= hv_map_level[i];
      end
  end

  // run-time ramp source for banks A and B
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      hv_rt_up_eff_out   <= '0;
      hv_rt_down_eff_out <= '0;
      hv_rt_instant_out  <= 1'b0;
    end
    else
    begin
      hv_rt_instant_out <= hv_ramp_sel_in[1];
      if (hv_ramp_sel_in == lbbpc_pkg::RAMP_START)
      begin
        hv_rt_up_eff_out   <= hv_start_time_in;
        hv_rt_down_eff_out <= hv_stop_time_in;
      end
      else
      begin
        hv_rt_up_eff_out   <= hv_rt_up_in;
        hv_rt_down_eff_out <= hv_rt_down_in;
      end
    end
  end

  // low-voltage bank levels, zero while the bank is off
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
      lv_bank_level_reg <= '0;
    else
      for (int i = 0; i < lbbpc_pkg::NUM_LV; i++)
        lv_bank_level_reg[i] <= lv_bank_en_in[i] ? lv_map_level[i] : 16'h0000;
  end

  // sink routing: each sink follows a bank of its own group
  always_comb
  begin
    for (int s = 0; s < lbbpc_pkg::NUM_LV; s++)
      sink_on_next[s] = lv_bank_on[sink_bank(3'(s), lv_sink_sel_in[s])];
  end

  // sink outputs do not look at the pump state at all
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      lv_sink_level_out     <= '0;
      lv_sink_fullscale_out <= '0;
      lv_sink_on_out        <= '0;
    end
    else
      for (int s = 0; s < lbbpc_pkg::NUM_LV; s++)
      begin
        lv_sink_level_out[s]     <= lv_bank_level_reg[sink_bank(3'(s), lv_sink_sel_in[s])];
        lv_sink_fullscale_out[s] <= lv_fullscale_in[sink_bank(3'(s), lv_sink_sel_in[s])];
        lv_sink_on_out[s]        <= sink_on_next[s];
      end
  end

  // feedback enables, all set after reset
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
      fb_en_reg <= lbbpc_pkg::FB_EN_RESET;
    else if (fb_en_wr_in)
      fb_en_reg <= fb_en_data_in;
  end

  // same bits steer the short fault trigger outside
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
      fb_en_out <= lbbpc_pkg::FB_EN_RESET;
    else
      fb_en_out <= fb_en_reg;
  end

  // comparator levels cross into this clock through two flops
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      head_meta_reg <= '0;
      head_sync_reg <= '0;
      cap_meta_reg  <= 1'b0;
      cap_sync_reg  <= 1'b0;
    end
    else
    begin
      head_meta_reg <= headroom_low_in;
      head_sync_reg <= head_meta_reg;
      cap_meta_reg  <= flying_capacitor_found_in;
      cap_sync_reg  <= cap_meta_reg;
    end
  end

  // only active sinks with feedback enabled may ask for 2x
  assign boost_req  = |(sink_on_next & fb_en_reg & head_sync_reg);
  assign any_active = |(sink_on_next & fb_en_reg);

  // pump gain state machine
  always_comb
  begin
    pump_next    = pump_reg;
    det_cnt_next = 8'h00;
    unique case (pump_mode_in)
      lbbpc_pkg::PUMP_DIS: pump_next = lbbpc_pkg::PS_OFF;
      lbbpc_pkg::PUMP_1X:  pump_next = lbbpc_pkg::PS_FORCE_1X;
      lbbpc_pkg::PUMP_2X:  pump_next = lbbpc_pkg::PS_FORCE_2X;
      lbbpc_pkg::PUMP_AUTO:
      begin
        unique case (pump_reg)
          lbbpc_pkg::PS_DETECT:
          begin
            if (det_cnt_reg >= 8'(lbbpc_pkg::DETECT_CYCLES - 1))
              pump_next = cap_sync_reg ? lbbpc_pkg::PS_AUTO_1X
                                       : lbbpc_pkg::PS_NOCAP_1X;
            else
              det_cnt_next = det_cnt_reg + 8'h01;
          end
          lbbpc_pkg::PS_AUTO_1X:
            if (boost_req)
              pump_next = lbbpc_pkg::PS_AUTO_2X;
          lbbpc_pkg::PS_AUTO_2X:
            if (!any_active)
              pump_next = lbbpc_pkg::PS_AUTO_1X;
          lbbpc_pkg::PS_NOCAP_1X:
            pump_next = lbbpc_pkg::PS_NOCAP_1X;
          default:
            pump_next = lbbpc_pkg::PS_DETECT;                    // entering auto
        endcase
      end
    endcase
  end

  // state and probe counter
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pump_reg    <= lbbpc_pkg::PS_OFF;
      det_cnt_reg <= 8'h00;
    end
    else
    begin
      pump_reg    <= pump_next;
      det_cnt_reg <= det_cnt_next;
    end
  end

  // pump drive outputs follow the next state so they align with pump_state_out
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pump_pass_en_out   <= 1'b0;
      pump_switch_en_out <= 1'b0;
      pump_gain2x_out    <= 1'b0;
      pump_state_out     <= 3'h0;
    end
    else
    begin
      pump_state_out     <= pump_next;
      pump_pass_en_out   <= (pump_next != lbbpc_pkg::PS_OFF) &&
                            (pump_next != lbbpc_pkg::PS_AUTO_2X) &&
                            (pump_next != lbbpc_pkg::PS_FORCE_2X);
      pump_switch_en_out <= (pump_next == lbbpc_pkg::PS_AUTO_2X) ||
                            (pump_next == lbbpc_pkg::PS_FORCE_2X);
      pump_gain2x_out    <= (pump_next == lbbpc_pkg::PS_AUTO_2X) ||
                            (pump_next == lbbpc_pkg::PS_FORCE_2X);
    end
  end
endmodule : lbbpc_top

// ==== design/lbbpc_pkg.sv ====
// Purpose: shared constants, state codes and the exponential table for the LED bank block
// Assumes: 16-bit normalised current levels, 65535 standing for full scale
// Notes:   the table is built at elaboration, never at run time
package lbbpc_pkg;
  localparam int CODE_W     = 11;                // widest brightness code
  localparam int BYTE_W     = 8;
  localparam int LSB_W      = 3;
  localparam int LEVEL_W    = 16;
  localparam int FS_W       = 5;
  localparam int NUM_HV     = 2;
  localparam int NUM_LV     = 6;
  localparam int GROUP_SIZE = 3;
  localparam int CLK_HZ     = 50_000_000;
  localparam int CLK_NS     = 1_000_000_000 / CLK_HZ;
  localparam int DETECT_TIME_NS = 2000;          // flying capacitor probe window
  localparam int DETECT_CYCLES  = (DETECT_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int DET_W      = 8;
  // 0.85 ** (1/5.8181818) in Q16: ratio between neighbouring codes
  localparam longint EXP_RATIO_Q16 = 63731;
  localparam longint EXP_FULL      = 65535;
  localparam logic [1:0] RAMP_SPLIT = 2'h0;      // separate start-up and run-time times
  localparam logic [1:0] RAMP_START = 2'h1;      // start-up times used at run time
  localparam logic [1:0] PUMP_DIS   = 2'h0;
  localparam logic [1:0] PUMP_AUTO  = 2'h1;
  localparam logic [1:0] PUMP_1X    = 2'h2;
  localparam logic [1:0] PUMP_2X    = 2'h3;
  localparam logic [NUM_LV-1:0] FB_EN_RESET = 6'h3F;

  typedef enum logic [2:0] {
    PS_OFF      = 3'h0,
    PS_DETECT   = 3'h1,
    PS_AUTO_1X  = 3'h2,
    PS_AUTO_2X  = 3'h3,
    PS_NOCAP_1X = 3'h4,
    PS_FORCE_1X = 3'h5,
    PS_FORCE_2X = 3'h6
  } lbbpc_pump_t;

  typedef logic [LEVEL_W-1:0] lbbpc_lut_t [256];

  // walk down from full scale, one ratio step per code
  function automatic lbbpc_lut_t build_exp_lut();
    lbbpc_lut_t t;
    longint     v;
    v = EXP_FULL;
    for (int i = 255; i >= 0; i--)
    begin
      t[i] = LEVEL_W'(v);
      v = (v * EXP_RATIO_Q16 + 32768) >>> 16;
    end
    return t;
  endfunction : build_exp_lut
endpackage : lbbpc_pkg

// ==== design/lbbpc_map_if.sv ====
// Purpose: carries one brightness code to the mapper and its level back
// Assumes: mapper is purely combinational
// Notes:   wide selects the 11-bit code form
`timescale 1ns/1ps
interface lbbpc_map_if;
  logic [10:0] code;
  logic        wide;
  logic        linear;
  logic [15:0] level;
  modport user   (output code, output wide, output linear, input level);
  modport mapper (input code, input wide, input linear, output level);
endinterface : lbbpc_map_if

// ==== design/lbbpc_mapper.sv ====
// Purpose: brightness code to normalised current level, exponential or linear
// Assumes: level 65535 means full-scale current
// Notes:   11-bit exponential interpolates between table entries on the 3 low bits
`timescale 1ns/1ps
module lbbpc_mapper
(
  lbbpc_map_if.mapper m
);
  localparam lbbpc_pkg::lbbpc_lut_t EXP_LUT = lbbpc_pkg::build_exp_lut();
  logic [7:0]  idx;
  logic [7:0]  idx_up;
  logic [2:0]  frac;
  logic [15:0] lo;
  logic [15:0] hi;
  logic [18:0] step;
  logic [15:0] lin;

  // table index: code for 8-bit, code/8 for 11-bit
  always_comb
  begin
    idx    = m.wide ? m.code[10:3] : m.code[7:0];
    frac   = m.wide ? m.code[2:0] : 3'h0;
    idx_up = (idx == 8'hFF) ? idx : idx + 8'h01;
    lo     = EXP_LUT[idx];
    hi     = EXP_LUT[idx_up];
    step   = 19'(hi - lo) * 19'(frac);
  end

  // linear: code*257 for 8-bit, code*32 + code/64 for 11-bit
  always_comb
  begin
    if (m.wide)
      lin = {m.code, 5'h00} + 16'(m.code[10:6]);
    else
      lin = {m.code[7:0], m.code[7:0]};
  end

  assign m.level = m.linear ? lin : lo + step[18:3];
endmodule : lbbpc_mapper

// ==== tb/lbbpc_top_sva.sv ====
// Purpose: port-level assertions for the LED bank and pump block
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   latencies are counted in clk_sys_in cycles at the ports
`timescale 1ns/1ps
module lbbpc_top_sva
(
  input wire logic             clk_sys_in,
  input wire logic             resetn_in,
  input wire logic             hv_linear_in,
  input wire logic [1:0]       hv_wide_in,
  input wire logic [1:0]       hv_msb_wr_in,
  input wire logic [1:0][7:0]  hv_msb_in,
  input wire logic [1:0]       hv_pwm_en_in,
  input wire logic [7:0]       pwm_duty_in,
  input wire logic [1:0]       hv_ramp_sel_in,
  input wire logic [3:0]       hv_start_time_in,
  input wire logic [3:0]       hv_stop_time_in,
  input wire logic             fb_en_wr_in,
  input wire logic [5:0]       fb_en_data_in,
  input wire logic [1:0]       pump_mode_in,
  input wire logic [5:0]       headroom_low_in,
  input wire logic [1:0][15:0] hv_level_out,
  input wire logic [3:0]       hv_rt_up_eff_out,
  input wire logic [3:0]       hv_rt_down_eff_out,
  input wire logic             hv_rt_instant_out,
  input wire logic [5:0]       lv_sink_on_out,
  input wire logic [5:0]       fb_en_out,
  input wire logic             pump_pass_en_out,
  input wire logic             pump_switch_en_out,
  input wire logic             pump_gain2x_out,
  input wire logic [2:0]       pump_state_out
);
  logic [7:0] det_cnt_reg;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);

  // length of the capacitor probe, in cycles
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
      det_cnt_reg <= 8'h00;
    else if (pump_state_out == 3'h1)
      det_cnt_reg <= det_cnt_reg + 8'h01;
    else
      det_cnt_reg <= 8'h00;
  end

  // pump outputs follow the mode
  a_pump_off_open: assert property (
    pump_mode_in == lbbpc_pkg::PUMP_DIS |=> pump_state_out == 3'h0 && !pump_pass_en_out
      && !pump_switch_en_out) else $error("pump not open when disabled");
  a_forced_1x_pass: assert property (
    pump_mode_in == lbbpc_pkg::PUMP_1X |=> pump_state_out == 3'h5 && pump_pass_en_out
      && !pump_switch_en_out) else $error("forced 1x not passing");
  a_forced_2x_gain: assert property (
    pump_mode_in == lbbpc_pkg::PUMP_2X |=> pump_state_out == 3'h6 && pump_gain2x_out
      && pump_switch_en_out && !pump_pass_en_out) else $error("forced 2x wrong");
  a_auto_boost_low: assert property (
    (pump_mode_in == lbbpc_pkg::PUMP_AUTO && pump_state_out inside {3'h2, 3'h3}
      && |(headroom_low_in & lv_sink_on_out & fb_en_out))[*4] |=> pump_state_out == 3'h3)
    else $error("auto pump did not boost");
  a_auto_release_off: assert property (
    $past(pump_state_out) == 3'h3 && pump_state_out == 3'h2 |->
      (lv_sink_on_out & fb_en_out) == 6'h00) else $error("2x left with sinks on");
  a_probe_length: assert property (
    $past(pump_state_out) == 3'h1 && pump_state_out inside {3'h2, 3'h4} |->
      det_cnt_reg inside {[lbbpc_pkg::DETECT_CYCLES-1:lbbpc_pkg::DETECT_CYCLES+1]})
    else $error("probe length wrong");
  a_fb_en_load: assert property (
    fb_en_wr_in ##1 (!fb_en_wr_in)[*3] |-> fb_en_out == $past(fb_en_data_in, 3))
    else $error("feedback enables not loaded");
  a_hv_lin8_apply: assert property (
    hv_msb_wr_in[0] && hv_linear_in && !hv_wide_in[0] && !hv_pwm_en_in[0] ##1
      (hv_linear_in && !hv_pwm_en_in[0] && !hv_msb_wr_in[0])[*2] |=>
      hv_level_out[0] == {2{$past(hv_msb_in[0], 3)}}) else $error("linear level wrong");
  a_lsb_no_apply: assert property (
    (!hv_msb_wr_in[0] && $stable(hv_linear_in) && $stable(hv_pwm_en_in[0])
      && $stable(pwm_duty_in))[*4] |=> $stable(hv_level_out[0]))
    else $error("level moved without msb write");
  a_ramp_instant: assert property (
    hv_ramp_sel_in[1] |=> hv_rt_instant_out) else $error("instant ramp missing");
  a_ramp_startup: assert property (
    hv_ramp_sel_in == lbbpc_pkg::RAMP_START |=> !hv_rt_instant_out
      && hv_rt_up_eff_out == $past(hv_start_time_in)
      && hv_rt_down_eff_out == $past(hv_stop_time_in)) else $error("start-up ramp wrong");
endmodule : lbbpc_top_sva

bind lbbpc_top lbbpc_top_sva u_sva (.clk_sys_in, .resetn_in, .hv_linear_in, .hv_wide_in,
  .hv_msb_wr_in, .hv_msb_in, .hv_pwm_en_in, .pwm_duty_in, .hv_ramp_sel_in, .hv_start_time_in,
  .hv_stop_time_in, .fb_en_wr_in, .fb_en_data_in, .pump_mode_in, .headroom_low_in,
  .hv_level_out, .hv_rt_up_eff_out, .hv_rt_down_eff_out, .hv_rt_instant_out, .lv_sink_on_out,
  .fb_en_out, .pump_pass_en_out, .pump_switch_en_out, .pump_gain2x_out, .pump_state_out);

// ==== tb/lbbpc_top_test.sv ====
// Purpose: self-checking bench for the LED bank and pump block
// Assumes: 50 MHz clock, inputs driven by NBA on rising edges
// Notes:   expected levels worked out from the mapping formulas
`timescale 1ns/1ps
module lbbpc_top_test;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic hv_linear_in, lv_linear_in, fb_en_wr_in, flying_capacitor_found_in;
  logic [1:0] hv_wide_in, hv_lsb_wr_in, hv_msb_wr_in, hv_pwm_en_in, hv_ramp_sel_in, pump_mode_in;
  logic [1:0][2:0] hv_lsb_in;
  logic [1:0][7:0] hv_msb_in;
  logic [7:0] pwm_duty_in;
  logic [3:0] hv_start_time_in, hv_stop_time_in, hv_rt_up_in, hv_rt_down_in;
  logic [5:0] lv_bank_en_in, lv_pattern_en_in, fb_en_data_in, headroom_low_in;
  logic [5:0][7:0] lv_bright_in, lv_pattern_code_in;
  logic [5:0][4:0] lv_fullscale_in, lv_sink_fullscale_out;
  logic [5:0][1:0] lv_sink_sel_in;
  logic [1:0][15:0] hv_level_out;
  logic [5:0][15:0] lv_sink_level_out;
  logic [3:0] hv_rt_up_eff_out, hv_rt_down_eff_out;
  logic [5:0] lv_sink_on_out, fb_en_out;
  logic hv_rt_instant_out, pump_pass_en_out, pump_switch_en_out, pump_gain2x_out;
  logic [2:0] pump_state_out;
  int fail_count = 0;
  int cmp_count = 0;

  // free-running system clock
  always #10 clk_sys_in = ~clk_sys_in;

  lbbpc_top u_dut (.clk_sys_in, .resetn_in, .hv_linear_in, .hv_wide_in, .hv_lsb_wr_in,
    .hv_msb_wr_in, .hv_lsb_in, .hv_msb_in, .hv_pwm_en_in, .pwm_duty_in, .hv_ramp_sel_in,
    .hv_start_time_in, .hv_stop_time_in, .hv_rt_up_in, .hv_rt_down_in, .lv_linear_in,
    .lv_bank_en_in, .lv_bright_in, .lv_fullscale_in, .lv_pattern_en_in, .lv_pattern_code_in,
    .lv_sink_sel_in, .fb_en_wr_in, .fb_en_data_in, .pump_mode_in, .headroom_low_in,
    .flying_capacitor_found_in, .hv_level_out, .hv_rt_up_eff_out, .hv_rt_down_eff_out,
    .hv_rt_instant_out, .lv_sink_level_out, .lv_sink_fullscale_out, .lv_sink_on_out,
    .fb_en_out, .pump_pass_en_out, .pump_switch_en_out, .pump_gain2x_out, .pump_state_out);

  // exponential level: one ratio step down from full scale per code
  function automatic logic [15:0] exp_lvl(input int c);
    longint v;
    v = lbbpc_pkg::EXP_FULL;
    for (int i = 255; i > c; i--)
      v = (v * lbbpc_pkg::EXP_RATIO_Q16 + 32768) >>> 16;
    return 16'(v);
  endfunction : exp_lvl

  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : cyc

  // lsb strobe, then msb strobe (mw=0 leaves the msb strobe low)
  task automatic hv_wr(input int b, input logic w, input logic [7:0] m, input logic [2:0] l,
                       input logic mw);
    @(posedge clk_sys_in);
    hv_lsb_in[b] <= l;
    hv_lsb_wr_in[b] <= 1'b1;
    @(posedge clk_sys_in);
    hv_lsb_wr_in[b] <= 1'b0;
    hv_msb_in[b] <= m;
    hv_wide_in[b] <= w;
    hv_msb_wr_in[b] <= mw;
    @(posedge clk_sys_in);
    hv_msb_wr_in[b] <= 1'b0;
    cyc(5);
  endtask : hv_wr

  task automatic fbw(input logic [5:0] d);
    @(posedge clk_sys_in);
    fb_en_data_in <= d;
    fb_en_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    fb_en_wr_in <= 1'b0;
    cyc(4);
    chk("fb_en", 16'(d), 16'(fb_en_out));
  endtask : fbw

  // forced or disabled mode, sinks must stay as they were
  task automatic pmode(input logic [1:0] m, input logic [2:0] st, input logic [1:0] ps);
    @(posedge clk_sys_in);
    pump_mode_in <= m;
    cyc(3);
    chk("pump_state", 16'(st), 16'(pump_state_out));
    chk("pump pass,switch", 16'(ps), 16'({pump_pass_en_out, pump_switch_en_out}));
    chk("pump gain", 16'(ps[0]), 16'(pump_gain2x_out));
    chk("sink on", 16'h0009, 16'(lv_sink_on_out));
  endtask : pmode

  task automatic wait_st(input logic [2:0] s);
    int i;
    for (i = 0; i < 400 && pump_state_out !== s; i++)
      @(posedge clk_sys_in);
    chk("pump_state", 16'(s), 16'(pump_state_out));
    if (i == 400)
      results();
  endtask : wait_st

  // main sequence
  initial
  begin
    {hv_linear_in, hv_wide_in, hv_lsb_wr_in, hv_msb_wr_in, hv_lsb_in, hv_msb_in, hv_pwm_en_in,
     pwm_duty_in, hv_ramp_sel_in, hv_start_time_in, hv_stop_time_in, hv_rt_up_in, hv_rt_down_in,
     lv_linear_in, lv_bank_en_in, lv_bright_in, lv_fullscale_in, lv_pattern_en_in,
     lv_pattern_code_in, lv_sink_sel_in, fb_en_wr_in, fb_en_data_in, pump_mode_in,
     headroom_low_in, flying_capacitor_found_in} <= '0;
    cyc(8);
    chk("fb_en", 16'h003F, 16'(fb_en_out));
    chk("pump", 16'h0000, 16'({pump_state_out, pump_pass_en_out}));
    resetn_in <= 1'b1;
    $display("test reset done");
    hv_linear_in <= 1'b1;
    hv_wr(0, 1'b0, 8'h80, 3'h0, 1'b1);
    chk("hv_a", 16'h8080, hv_level_out[0]);
    hv_wr(1, 1'b0, 8'hFF, 3'h0, 1'b1);
    chk("hv_b", 16'hFFFF, hv_level_out[1]);
    hv_linear_in <= 1'b0;
    cyc(4);
    chk("hv_a", exp_lvl(128), hv_level_out[0]);
    chk("hv_b", exp_lvl(255), hv_level_out[1]);
    hv_wr(0, 1'b1, 8'h40, 3'h0, 1'b1);
    chk("hv_a", exp_lvl(64), hv_level_out[0]);
    hv_linear_in <= 1'b1;
    hv_wr(0, 1'b1, 8'hFF, 3'h5, 1'b1);
    chk("hv_a", 16'hFFBF, hv_level_out[0]);
    hv_wr(0, 1'b1, 8'h10, 3'h7, 1'b0);
    chk("hv_a", 16'hFFBF, hv_level_out[0]);
    hv_wr(0, 1'b1, 8'h10, 3'h7, 1'b1);
    chk("hv_a", 16'h10E2, hv_level_out[0]);
    hv_pwm_en_in <= 2'h2;
    pwm_duty_in <= 8'h7F;
    cyc(4);
    chk("hv_b", 16'h7FFF, hv_level_out[1]);
    chk("hv_a", 16'h10E2, hv_level_out[0]);
    $display("test brightness done");
    hv_start_time_in <= 4'h3;
    hv_stop_time_in <= 4'h5;
    hv_rt_up_in <= 4'h9;
    hv_rt_down_in <= 4'hC;
    for (int s = 0; s < 4; s++)
    begin
      hv_ramp_sel_in <= 2'(s);
      cyc(3);
      chk("rt_instant", 16'(s / 2), 16'(hv_rt_instant_out));
      if (s < 2)
      begin
        chk("rt_up", (s == 1) ? 16'h3 : 16'h9, 16'(hv_rt_up_eff_out));
        chk("rt_down", (s == 1) ? 16'h5 : 16'hC, 16'(hv_rt_down_eff_out));
      end
    end
    $display("test ramp done");
    lv_linear_in <= 1'b1;
    lv_bright_in[0] <= 8'hFF;
    lv_bright_in[4] <= 8'h40;
    lv_fullscale_in[0] <= 5'h1F;
    lv_bank_en_in <= 6'h11;
    lv_sink_sel_in <= {2'h0, 2'h0, 2'h1, 2'h3, 2'h3, 2'h0};
    lv_pattern_code_in[0] <= 8'h10;
    cyc(4);
    chk("sink1", 16'hFFFF, lv_sink_level_out[0]);
    chk("sink1 fs", 16'h001F, 16'(lv_sink_fullscale_out[0]));
    chk("sink4", 16'h4040, lv_sink_level_out[3]);
    chk("sink on", 16'h0009, 16'(lv_sink_on_out));
    lv_pattern_en_in <= 6'h01;
    lv_linear_in <= 1'b0;
    cyc(4);
    chk("sink1", exp_lvl(16), lv_sink_level_out[0]);
    chk("sink4", exp_lvl(64), lv_sink_level_out[3]);
    lv_pattern_en_in <= 6'h00;
    $display("test sinks done");
    pmode(2'h3, 3'h6, 2'h1);
    pmode(2'h2, 3'h5, 2'h2);
    pmode(2'h0, 3'h0, 2'h0);
    $display("test forced pump done");
    flying_capacitor_found_in <= 1'b1;
    fbw(6'h3E);
    headroom_low_in <= 6'h01;
    pump_mode_in <= 2'h1;
    wait_st(3'h2);
    cyc(10);
    chk("pump_state", 16'h0002, 16'(pump_state_out));
    fbw(6'h3F);
    wait_st(3'h3);
    headroom_low_in <= 6'h00;
    cyc(10);
    chk("pump_state", 16'h0003, 16'(pump_state_out));
    lv_bright_in[0] <= 8'h00;
    lv_bank_en_in <= 6'h01;
    wait_st(3'h2);
    pump_mode_in <= 2'h0;
    flying_capacitor_found_in <= 1'b0;
    cyc(3);
    pump_mode_in <= 2'h1;
    wait_st(3'h4);
    chk("pump pass,gain", 16'h0002, 16'({pump_pass_en_out, pump_gain2x_out}));
    $display("test auto pump done");
    results();
  end
endmodule : lbbpc_top_test
